/* shared/bus_node_pkg.sv */
// Functional notes
// - Only one master at a time; take bus only when idle and granted.
// - Grants travel from the arbiter at the front toward the back end.
// - A grant at a level we do not request is passed on unchanged.
// - A grant at a level we request is blocked; we become next master.
// - Nearer device on the same level wins, seeing the grant first.
// - Arbitration may proceed while another master still transfers.
// - Non-processor winner may transfer between any two bus devices.
// - Interrupting devices must request on a processor level, never non-processor.
// - No bus clock; each transfer advances only by the sync handshake.
// - Read: drive slave address first, then assert master sync.
// - No fixed delay between master sync and slave sync; master waits.
package bus_node_pkg;
	localparam int NUM_LEVELS  = 5;
	localparam int ADDR_W      = 18;
	localparam int DATA_W      = 16;
	// Level positions on the request and grant vectors
	localparam int LVL_IRQ4    = 0;
	localparam int LVL_IRQ5    = 1;
	localparam int LVL_IRQ6    = 2;
	localparam int LVL_IRQ7    = 3;
	localparam int LVL_NONPROC = 4;
	// Address settle time before master sync, in ns, and the derived cycle count
	localparam int CLK_PERIOD_PS   = 4000;
	localparam int ADDR_SETUP_NS   = 150;
	localparam int ADDR_SETUP_CYC  = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_CNT_W     = 8;
	localparam logic [SETUP_CNT_W-1:0] SETUP_CNT_RESET = 8'h00;
	localparam logic [DATA_W-1:0]      RDATA_RESET     = 16'h0000;

	typedef struct packed {
		logic              nonproc;     // Non-processor request when set and interrupt clear
		logic [1:0]        irq_level;   // 3 = level 7 .. 0 = level 4
		logic              interrupt;   // Transfer is for interrupting the processor
		logic              write;       // Write word when set, else read word
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              write;
	} resp_t;

	typedef enum logic [5:0] {
		ST_IDLE    = 6'b000001,
		ST_REQUEST = 6'b000010,
		ST_WAITBUS = 6'b000100,
		ST_SETUP   = 6'b001000,
		ST_WAITACK = 6'b010000,
		ST_RELEASE = 6'b100000
	} state_t;
endpackage : bus_node_pkg

/* verilog/grant_chain_cell.sv */
`timescale 1ns/1ps
`default_nettype none
module grant_chain_cell
	import bus_node_pkg::*;
#(
	parameter int LEVELS = NUM_LEVELS
) (
	input  wire logic              clk,          // System clock
	input  wire logic              resetn,       // Async reset, active low
	input  wire logic [LEVELS-1:0] grant_pin,    // Grant lines from the arbiter side
	input  wire logic [LEVELS-1:0] want,         // One-hot level we are requesting
	output logic      [LEVELS-1:0] grant_fwd,    // Grant lines toward the back end
	output logic                   won           // High while we hold a blocked grant
);
	logic [LEVELS-1:0] sync1_reg;
	logic [LEVELS-1:0] sync2_reg;
	logic [LEVELS-1:0] prev_reg;
	logic [LEVELS-1:0] block_reg;

	genvar g;
	generate
		for (g = 0; g < LEVELS; g++) begin : g_level
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					sync1_reg[g] <= 1'b0;
					sync2_reg[g] <= 1'b0;
					prev_reg[g]  <= 1'b0;
					block_reg[g] <= 1'b0;
				end else begin
					sync1_reg[g] <= grant_pin[g];
					sync2_reg[g] <= sync1_reg[g];
					prev_reg[g]  <= sync2_reg[g];
					// Claim only on the grant's arrival so a late request never chops a grant
					// already passed downstream
					if (!sync2_reg[g])
						block_reg[g] <= 1'b0;
					else if (!prev_reg[g] && want[g])
						block_reg[g] <= 1'b1;
				end
			end
			// Unwanted grants ripple on toward the back end
			assign grant_fwd[g] = sync2_reg[g] & ~block_reg[g] & ~(want[g] & ~prev_reg[g]);
		end
	endgenerate

	assign won = |block_reg;
endmodule : grant_chain_cell
`default_nettype wire

/* verilog/bus_requester.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_requester
	import bus_node_pkg::*;
#(
	parameter int LEVELS = NUM_LEVELS
) (
	input  wire logic              clk,            // System clock, 250 MHz
	input  wire logic              resetn,         // Async reset, active low
	// User side
	input  wire logic              cmd_valid,      // Command offered
	output logic                   cmd_ready,      // Command accepted this cycle
	input  wire cmd_t              cmd,            // Transfer command
	output logic                   resp_valid,     // One-cycle completion pulse
	output resp_t                  resp,           // Completion data, registered
	output logic                   busy,           // Node is arbitrating or transferring
	// Arbitration lines
	output logic      [LEVELS-1:0] request_out,    // Request line value (asserted high)
	output logic      [LEVELS-1:0] request_oe,     // Request line drive enable
	input  wire logic [LEVELS-1:0] grant_in,       // Grants from the front end side
	output logic      [LEVELS-1:0] grant_out,      // Grants passed toward the back end
	input  wire logic              bus_busy_in,    // Some master owns the bus
	output logic                   bus_busy_out,   // Bus busy value
	output logic                   bus_busy_oe,    // Bus busy drive enable
	// Data transfer lines
	output logic      [ADDR_W-1:0] addr_out,       // Slave address
	output logic                   addr_oe,        // Address drive enable
	input  wire logic [DATA_W-1:0] data_in,        // Data lines as seen on the bus
	output logic      [DATA_W-1:0] data_out,       // Write data
	output logic                   data_oe,        // Data drive enable
	output logic                   control_write,  // High for a write transfer
	output logic                   master_sync_strobe,    // Master sync value
	output logic                   master_sync_oe,        // Master sync drive enable
	input  wire logic              slave_sync_ack  // Slave sync from the bus
);
	// No slave timeout: a slave that never answers holds the bus until reset
	// Arbitration and handshake run on synchronised copies, trading a few cycles for safety
	state_t                 state_reg;
	cmd_t                   cmd_reg;
	logic [LEVELS-1:0]      want_reg;
	logic [SETUP_CNT_W-1:0] setup_cnt_reg;
	logic [DATA_W-1:0]      rdata_reg;
	logic                   resp_valid_reg;
	logic                   won;
	// Synchronised copies of pins driven by other devices
	logic                   busy_s1_reg;
	logic                   busy_s2_reg;
	logic                   ssync_s1_reg;
	logic                   ssync_s2_reg;
	logic [LEVELS-1:0]      want_next;

	// Busy, slave sync and grant pins from other devices pass two flops before any logic reads them
	// Bus busy is the wired-OR of every master, our own drive included
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			busy_s1_reg <= bus_busy_in;
			busy_s2_reg <= busy_s1_reg;
		end
	end

	// Slave sync costs two cycles of latency; the handshake tolerates any delay
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ssync_s1_reg <= 1'b0;
			ssync_s2_reg <= 1'b0;
		end else begin
			ssync_s1_reg <= slave_sync_ack;
			ssync_s2_reg <= ssync_s1_reg;
		end
	end

	// Pick the request line for a new command
	always_comb begin
		want_next = '0;
		if (cmd.nonproc && !cmd.interrupt) begin
			want_next[LVL_NONPROC] = 1'b1;
		end else begin
			// Interrupting transfers always use a processor level
			case (cmd.irq_level)
				2'h3:    want_next[LVL_IRQ7] = 1'b1;
				2'h2:    want_next[LVL_IRQ6] = 1'b1;
				2'h1:    want_next[LVL_IRQ5] = 1'b1;
				default: want_next[LVL_IRQ4] = 1'b1;
			endcase
		end
	end

	grant_chain_cell #(
		.LEVELS    (LEVELS)
	) u_chain (
		.clk       (clk),
		.resetn    (resetn),
		.grant_pin (grant_in),
		.want      (want_reg),
		.grant_fwd (grant_out),
		.won       (won)
	);

	// Handshake output straight from state, high only while idle
	assign cmd_ready = state_reg == ST_IDLE;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					// Commands are taken only here, one word per command
					if (cmd_valid)
						state_reg <= ST_REQUEST;
				end
				ST_REQUEST: begin
					// Winning may happen while another master still transfers
					if (won)
						state_reg <= ST_WAITBUS;
				end
				ST_WAITBUS: begin
					// Take the bus only once the previous master and slave have let go
					if (!busy_s2_reg && !ssync_s2_reg)
						state_reg <= ST_SETUP;
				end
				ST_SETUP: begin
					// Address, and write data, stand for the whole settle time before master sync
					if (setup_cnt_reg == SETUP_CNT_W'(ADDR_SETUP_CYC - 1))
						state_reg <= ST_WAITACK;
				end
				ST_WAITACK: begin
					// No timeout: a slow slave is given all the time it needs
					if (ssync_s2_reg)
						state_reg <= ST_RELEASE;
				end
				ST_RELEASE: begin
					// Keep the address up until the slave has let go of slave sync
					if (!ssync_s2_reg)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Command is held until the next one is taken, so the bus sees a steady address
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			cmd_reg <= '0;
		else if (state_reg == ST_IDLE && cmd_valid)
			cmd_reg <= cmd;
	end

	// Requested level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			want_reg <= '0;
		end else begin
			if (state_reg == ST_IDLE && cmd_valid) begin
				want_reg <= want_next;
			end else if (state_reg == ST_REQUEST && won) begin
				// Drop the request once the grant is held so the arbiter can move on
				want_reg <= '0;
			end
		end
	end

	// Address settle counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			setup_cnt_reg <= SETUP_CNT_RESET;
		else if (state_reg == ST_SETUP)
			setup_cnt_reg <= setup_cnt_reg + SETUP_CNT_W'(1);
		else
			setup_cnt_reg <= SETUP_CNT_RESET;
	end

	// Read data is taken at slave sync, which doubles as the data strobe
	// Data lines settle before slave sync rises and the synchroniser adds two more cycles
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata_reg <= RDATA_RESET;
		else if (state_reg == ST_WAITACK && ssync_s2_reg && !cmd_reg.write)
			rdata_reg <= data_in;
	end

	// Completion pulse for reads and writes alike
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			resp_valid_reg <= 1'b0;
		else
			resp_valid_reg <= state_reg == ST_WAITACK && ssync_s2_reg;
	end

	assign resp_valid = resp_valid_reg;
	assign resp.rdata = rdata_reg;
	assign resp.write = cmd_reg.write;
	assign busy       = state_reg != ST_IDLE;

	// Request lines are wired-OR: drive only our own level, only while it is wanted
	assign request_out = want_reg;
	assign request_oe  = want_reg;

	// Bus ownership from setup through the end of the handshake
	logic owner;
	assign owner        = state_reg == ST_SETUP || state_reg == ST_WAITACK || state_reg == ST_RELEASE;
	assign bus_busy_out = owner;
	assign bus_busy_oe  = owner;

	// Address drive enable follows ownership, data drive enable too on writes, so both are let go together
	assign addr_out       = cmd_reg.addr;
	assign addr_oe        = owner;
	assign control_write  = cmd_reg.write;
	assign data_out       = cmd_reg.wdata;
	assign data_oe        = owner && cmd_reg.write;

	// Master sync only after the address has settled, and dropped once slave sync is seen
	assign master_sync_strobe = state_reg == ST_WAITACK;
	assign master_sync_oe     = state_reg == ST_WAITACK;
endmodule : bus_requester
`default_nettype wire

/* tb/bus_requester_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_requester_monitor
	import bus_node_pkg::*;
#(
	parameter int LEVELS = NUM_LEVELS
) (
	input wire logic              clk,                // Clock
	input wire logic              resetn,             // Reset
	input wire logic [LEVELS-1:0] request_out,        // Request
	input wire logic [LEVELS-1:0] request_oe,         // Request drive
	input wire logic [LEVELS-1:0] grant_in,           // Grant in
	input wire logic [LEVELS-1:0] grant_out,          // Grant out
	input wire logic              bus_busy_oe,        // Owner
	input wire logic              addr_oe,            // Address drive
	input wire logic              data_oe,            // Data drive
	input wire logic              control_write,      // Write
	input wire logic              master_sync_strobe, // Master sync
	input wire logic              master_sync_oe,     // Master sync drive
	input wire logic              slave_sync_ack,     // Slave sync
	input wire logic              resp_valid          // Done
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_one_level_req: assert property ($onehot0(request_out & request_oe))
		else $error("two levels");
	a_fwd_only_grant: assert property ((grant_out & ~$past(grant_in, 2)) == '0)
		else $error("grant made up");
	a_no_req_owner: assert property (bus_busy_oe |-> request_oe == '0)
		else $error("owner requests");
	a_sync_has_addr: assert property (master_sync_strobe |-> addr_oe && bus_busy_oe)
		else $error("sync no addr");
	a_addr_before_sync: assert property ($rose(addr_oe) |-> !master_sync_strobe [*8])
		else $error("sync early");
	a_sync_waits_ack: assert property (master_sync_strobe && !slave_sync_ack |=> master_sync_strobe)
		else $error("sync dropped");
	a_resp_after_ack: assert property (resp_valid |-> $past(slave_sync_ack, 2))
		else $error("done no ack");
	a_resp_one_cycle: assert property (resp_valid |=> !resp_valid)
		else $error("done long");
	a_data_on_write: assert property (data_oe |-> control_write && bus_busy_oe)
		else $error("data drive");
	a_sync_late: assert property ($rose(master_sync_strobe) |-> $past(addr_oe, 8))
		else $error("sync before address settled");
	a_addr_held: assert property ($fell(master_sync_strobe) |-> addr_oe && !master_sync_oe)
		else $error("address dropped with sync");
endmodule : bus_requester_monitor
bind bus_requester bus_requester_monitor #(.LEVELS(LEVELS)) mon_u (.*);
`default_nettype wire

/* tb/bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_partner
	import bus_node_pkg::*;
(
	input  wire logic              clk,     // Clock
	input  wire logic              resetn,  // Reset, active low
	input  wire logic [4:0]        dut_req, // Requests of the node
	input  wire logic [4:0]        ext_req, // Requests from behind it
	input  wire logic              consent, // Processor allows level grants
	input  wire logic              msync,   // Master sync as driven
	input  wire logic [ADDR_W-1:0] addr,    // Address lines
	input  wire logic [DATA_W-1:0] data,    // Resolved data lines
	input  wire logic [2:0]        slow,    // Slave delay
	output logic      [4:0]        grant,   // Front end grants
	output logic      [DATA_W-1:0] sdata,   // Slave data
	output logic                   ssync,   // Slave sync
	output logic      [DATA_W-1:0] wr_seen  // Word written
);
	logic [4:0] req;
	logic [4:0] prev;
	logic [2:0] cnt;
	assign req = dut_req | ext_req;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			grant <= '0;
			prev  <= '0;
		end else begin
			prev <= dut_req;
			if (grant != '0) begin
				// Held until withdrawn or blocked, so one grant stands at a time
				if ((grant & req) == '0 || (grant & prev & ~dut_req) != '0) grant <= '0;
			end else if (req[LVL_NONPROC]) begin
				grant <= 5'h10;
			end else if (consent) begin
				grant <= req[3] ? 5'h08 : req[2] ? 5'h04 : req[1] ? 5'h02 : {4'h0, req[0]};
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ssync   <= 1'h0;
			cnt     <= '0;
			sdata   <= 16'hFFFF;
			wr_seen <= '0;
		end else if (msync && !ssync) begin
			cnt <= cnt + 3'h1;
			if (cnt == slow) begin
				ssync   <= 1'h1;
				sdata   <= addr[15:0] ^ 16'h5A3C;
				wr_seen <= data;
			end
		end else if (!msync) begin
			ssync <= 1'h0;
			cnt   <= '0;
			sdata <= ~sdata; // Released lines never keep a stale word
		end
	end
endmodule : bus_partner
`default_nettype wire

/* tb/async_bus_priority_arbiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module async_bus_priority_arbiter_tb;
	import bus_node_pkg::*;
	localparam int LIM = 4000;
	logic clk = 1'h0, resetn = 1'h0, cmd_valid = 1'h0, consent = 1'h1, other_busy = 1'h0;
	cmd_t cmd = '0;
	logic [4:0] ext_raise = '0, ext_req = '0, ext_got = '0;
	logic [2:0] slow = '0;
	logic [DATA_W-1:0] last_rd = '0;
	int bad_count = 0, cmp_count = 0, n, m;
	resp_t expq[$];
	wire logic cmd_ready, resp_valid, busy, bb_out, bb_oe, addr_oe, data_oe, cwr, ms, ms_oe, ssync;
	wire resp_t resp;
	wire logic [4:0] req_o, req_oe, gin, gout;
	wire logic [ADDR_W-1:0] addr;
	wire logic [DATA_W-1:0] dout, din, sdata, wr_seen;
	assign din = data_oe ? dout : sdata;
	bus_requester dut_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.resp_valid(resp_valid), .resp(resp), .busy(busy), .request_out(req_o), .request_oe(req_oe),
		.grant_in(gin), .grant_out(gout), .bus_busy_in(other_busy | (bb_oe & bb_out)), .bus_busy_out(bb_out),
		.bus_busy_oe(bb_oe), .addr_out(addr), .addr_oe(addr_oe), .data_in(din), .data_out(dout),
		.data_oe(data_oe), .control_write(cwr), .master_sync_strobe(ms), .master_sync_oe(ms_oe),
		.slave_sync_ack(ssync));
	bus_partner far_u (.clk(clk), .resetn(resetn), .dut_req(req_o & req_oe), .ext_req(ext_req), .consent(consent),
		.msync(ms & ms_oe), .addr(addr), .data(din), .slow(slow), .grant(gin), .sdata(sdata), .ssync(ssync),
		.wr_seen(wr_seen));
	initial begin
		forever #2 clk = ~clk;
	end
	// Device further down the chain: drops a level once the grant reaches it
	always @(posedge clk) begin
		ext_req <= (ext_req | ext_raise) & ~gout;
		ext_got <= ext_got | (ext_req & gout);
	end
	always @(posedge clk) begin
		if (resp_valid === 1'h1) begin
			if (expq.size() == 0) chk("spare resp", 0, 1);
			else chk("resp", expq.pop_front(), resp);
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("unexpected %s: expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task tmo(input int k);
		if (k >= LIM) begin
			bad_count++;
			$display("unexpected wait: expected done seen timeout");
			finish_test();
		end
	endtask : tmo
	task finish_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task do_cmd(input logic np, input logic [1:0] lv, input logic it, input logic wr);
		cmd_t c;
		logic [DATA_W-1:0] rd;
		c = cmd_t'{nonproc: np, irq_level: lv, interrupt: it, write: wr,
			addr: 18'($urandom) & 18'h3FFFE, wdata: 16'($urandom)};
		rd = wr ? last_rd : c.addr[15:0] ^ 16'h5A3C;
		last_rd = rd;
		expq.push_back({rd, wr});
		chk("ready", 1, cmd_ready);
		@(posedge clk);
		slow <= 3'($urandom);
		cmd <= c;
		cmd_valid <= 1'h1;
		@(posedge clk);
		cmd_valid <= 1'h0;
		for (n = 0; n < LIM && req_oe == '0; n++) @(posedge clk);
		tmo(n);
		chk("level", (np && !it) ? 5'h10 : 5'h01 << lv, req_o);
		for (n = 0; n < LIM && busy !== 1'h0; n++) @(posedge clk);
		tmo(n);
		if (wr) chk("wdata", c.wdata, wr_seen);
	endtask : do_cmd
	initial begin
		void'($urandom(32'h9A5F));
		repeat (4) @(posedge clk);
		resetn <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			do_cmd(i >= 4, (i == 5) ? 2'h2 : 2'(i), i == 5, i[0]);
			$display("test %0d done", i);
		end
		fork
			do_cmd(1'h0, 2'h3, 1'h0, 1'h0);
			begin
				consent <= 1'h0;
				repeat (60) @(posedge clk);
				chk("held req", 5'h08, req_oe);
				consent <= 1'h1;
			end
		join
		$display("test 6 done");
		other_busy <= 1'h1;
		fork
			do_cmd(1'h1, 2'h0, 1'h0, 1'h1);
			begin
				for (m = 0; m < LIM && req_oe == '0; m++) @(posedge clk);
				for (m = m; m < LIM && req_oe != '0; m++) @(posedge clk);
				tmo(m);
				repeat (40) @(posedge clk);
				chk("owner", 0, bb_oe);
				other_busy <= 1'h0;
			end
		join
		$display("test 7 done");
		fork
			do_cmd(1'h0, 2'h3, 1'h0, 1'h1);
			begin
				ext_raise <= 5'h18;
				@(posedge clk);
				ext_raise <= '0;
				for (m = 0; m < LIM && req_oe == '0; m++) @(posedge clk);
				for (m = m; m < LIM && req_oe != '0; m++) @(posedge clk);
				tmo(m);
				chk("first", 5'h10, ext_got);
			end
		join
		for (m = 0; m < LIM && ext_got != 5'h18; m++) @(posedge clk);
		chk("last", 5'h18, ext_got);
		chk("queue", 0, expq.size());
		$display("test 8 done");
		finish_test();
	end
endmodule : async_bus_priority_arbiter_tb
`default_nettype wire
